// >>> design/pcg_pkg.sv
package pcg_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] PCG_OFS_BUS1_RST = 8'h10;
   localparam logic [7:0] PCG_OFS_FAST_GATE = 8'h14;
   localparam logic [7:0] PCG_OFS_BUS2_GATE = 8'h18;
   localparam logic [7:0] PCG_OFS_BUS1_GATE = 8'h1C;
   localparam logic [7:0] PCG_OFS_BKP_CTRL = 8'h20;

   // ****************************************
   // Reset values and writable masks
   // ****************************************
   localparam logic [31:0] PCG_RST_FAST_GATE = 32'h0000_0014;
   localparam logic [31:0] PCG_RST_BUS2_GATE = 32'h0000_0000;
   localparam logic [31:0] PCG_RST_BUS1_GATE = 32'h0000_0000;
   localparam logic [31:0] PCG_RST_BUS1_RST = 32'h0000_0000;
   localparam logic [31:0] PCG_RST_BKP_CTRL = 32'h0000_0018;
   localparam logic [31:0] PCG_MSK_FAST_GATE = 32'h014E_0055;
   localparam logic [31:0] PCG_MSK_BUS2_GATE = 32'h0041_5A01;
   localparam logic [31:0] PCG_MSK_BUS1_GATE = 32'h1222_0913;
   localparam logic [31:0] PCG_MSK_BUS1_RST = 32'h1222_0900;

   // ****************************************
   // Backup-domain control field positions
   // ****************************************
   localparam int PCG_BIT_XTAL_EN = 0;
   localparam int PCG_BIT_XTAL_RDY = 1;
   localparam int PCG_BIT_XTAL_BYP = 2;
   localparam int PCG_BIT_DRV_LO = 3;
   localparam int PCG_BIT_DRV_HI = 4;
   localparam int PCG_BIT_SRC_LO = 8;
   localparam int PCG_BIT_SRC_HI = 9;
   localparam int PCG_BIT_RTC_EN = 15;
   localparam int PCG_BIT_BKP_RST = 16;

   // Wait states after a backup-domain access (0 to 3)
   localparam logic [1:0] PCG_BKP_WAIT_IDLE = 2'h0;
   localparam logic [1:0] PCG_BKP_WAIT_B2B = 2'h3;

   typedef enum logic [1:0] {
      PCG_SRC_NONE = 2'h0,
      PCG_SRC_XTAL = 2'h1,
      PCG_SRC_INT = 2'h2,
      PCG_SRC_FAST_DIV = 2'h3
   } pcg_src_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pcg_wb_req_t;

   typedef struct packed {
      logic ack;
      logic err;
      logic [31:0] dat;
   } pcg_wb_rsp_t;

   typedef struct packed {
      logic xtal_en;
      logic xtal_byp;
      logic [1:0] xtal_drv;
      pcg_src_t rtc_src;
      logic rtc_en;
      logic bkp_rst;
   } pcg_bkp_t;

endpackage

// >>> design/pcg_ctrl.sv
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// (RQ1) A peripheral read returns zero while its mask bit is clear in all three gate registers (fast, bus-2, bus-1).
// (RQ2) Fast-bus gates: DMA 0, CRC 6, ports A/B/C/F 17-19/22, coprocessor 24.
// (RQ3) Fast-bus bits 2 and 4 keep RAM and flash clocked in sleep.
// (RQ4) Fast-bus gate register resets to only bits 2 and 4 set.
// (RQ5) Bus-2 gates: sysconfig, converter, timer1, SPI, serial1, timer7, debug.
// (RQ6) Bus-1 gates: timers 2,3,6,4, watchdog, serial2, two-wire, fieldbus, power.
// (RQ7) Bus-1 reset bits 8,11,17,21,25,28 reset their peripherals; zero no effect.
// (RQ8) Bus-1 gate access stalls while a bus-1 peripheral access is in progress.
// (RQ9) Fast-bus gate register takes word, half, byte access with no wait.
// (RQ10) Crystal enable, bypass, source, RTC enable writes need backup unlock.
// (RQ11) Bit 1 follows crystal stability, hardware set and cleared.
// (RQ12) Bit 2 selects bypass external clock or resonator oscillator.
// (RQ13) Drive strength bits 4:3 writable, restored on backup-domain reset.
// (RQ14) Source 00 none, 01 crystal, 10 internal, 11 fast crystal div 32.
// (RQ15) Source changes only after backup-domain reset; direct change refused.
// (RQ16) Backup control resets to 0x18, only by backup-domain reset.
// (RQ17) Backup control takes 0 to 3 wait states, more when back to back.
// (RQ18) Bit 0 switches the slow crystal oscillator on and off.
// (RQ19) Bit 15 gates the RTC clock.
// (RQ20) Bit 16 holds the backup domain in reset while set.
// (RQ21) Peripheral reset stays asserted while its bit stays set.
// (RQ22) Reserved bits read zero and ignore writes.
module pcg_ctrl (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic bkp_por_i,
   input wire pcg_pkg::pcg_wb_req_t wb_req_i,
   output pcg_pkg::pcg_wb_rsp_t wb_rsp_o,
   input wire logic backup_write_unlock_i,
   input wire logic slow_crystal_stable_i,
   input wire logic bus1_periph_busy_i,
   input wire logic periph_sel_i,
   input wire logic [31:0] periph_gate_mask_i,
   input wire logic [31:0] periph_rdata_i,
   output logic [31:0] periph_rdata_o,
   output logic [31:0] fast_gate_o,
   output logic [31:0] bus2_gate_o,
   output logic [31:0] bus1_gate_o,
   output logic [31:0] bus1_rst_o,
   output pcg_pkg::pcg_bkp_t bkp_ctrl_o,
   output logic bkp_domain_rst_o
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel,
                                              input logic [31:0] msk);
      logic [31:0] lane;
      lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      byte_merge = ((old_v & ~lane) | (new_v & lane)) & msk;
   endfunction

   // Register word from the backup fields; reserved positions stay zero
   function automatic logic [31:0] bkp_pack(input pcg_pkg::pcg_bkp_t b,
                                            input logic rdy);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[pcg_pkg::PCG_BIT_XTAL_EN] = b.xtal_en;
      w[pcg_pkg::PCG_BIT_XTAL_RDY] = rdy;
      w[pcg_pkg::PCG_BIT_XTAL_BYP] = b.xtal_byp;
      w[pcg_pkg::PCG_BIT_DRV_HI:pcg_pkg::PCG_BIT_DRV_LO] = b.xtal_drv;
      w[pcg_pkg::PCG_BIT_SRC_HI:pcg_pkg::PCG_BIT_SRC_LO] = b.rtc_src;
      w[pcg_pkg::PCG_BIT_RTC_EN] = b.rtc_en;
      w[pcg_pkg::PCG_BIT_BKP_RST] = b.bkp_rst;
      bkp_pack = w;
   endfunction

   function automatic pcg_pkg::pcg_bkp_t bkp_unpack(input logic [31:0] w);
      pcg_pkg::pcg_bkp_t b;
      b.xtal_en = w[pcg_pkg::PCG_BIT_XTAL_EN];
      b.xtal_byp = w[pcg_pkg::PCG_BIT_XTAL_BYP];
      b.xtal_drv = w[pcg_pkg::PCG_BIT_DRV_HI:pcg_pkg::PCG_BIT_DRV_LO];
      b.rtc_src = pcg_pkg::pcg_src_t'(w[pcg_pkg::PCG_BIT_SRC_HI:pcg_pkg::PCG_BIT_SRC_LO]);
      b.rtc_en = w[pcg_pkg::PCG_BIT_RTC_EN];
      b.bkp_rst = w[pcg_pkg::PCG_BIT_BKP_RST];
      bkp_unpack = b;
   endfunction

   // ****************************************
   // Synchronisers
   // ****************************************
   logic rdy_meta_reg;
   logic rdy_sync_reg;
   logic busy_meta_reg;
   logic busy_sync_reg;
   logic bpor_meta_reg;
   logic bpor_sync_reg;

   always_ff @(posedge clk_i) begin
      rdy_meta_reg <= slow_crystal_stable_i;
      rdy_sync_reg <= rdy_meta_reg;
      busy_meta_reg <= bus1_periph_busy_i;
      busy_sync_reg <= busy_meta_reg;
      bpor_meta_reg <= bkp_por_i;
      bpor_sync_reg <= bpor_meta_reg;
   end

   // ****************************************
   // Bus decode
   // ****************************************
   logic req;
   logic hit_fast;
   logic hit_bus2;
   logic hit_bus1g;
   logic hit_bus1r;
   logic hit_bkp;
   logic mapped;
   logic ack_reg;
   logic ack_next;
   logic [1:0] wait_reg;

   assign req = wb_req_i.cyc & wb_req_i.stb & ~ack_reg;
   assign hit_fast = wb_req_i.adr == pcg_pkg::PCG_OFS_FAST_GATE;
   assign hit_bus2 = wb_req_i.adr == pcg_pkg::PCG_OFS_BUS2_GATE;
   assign hit_bus1g = wb_req_i.adr == pcg_pkg::PCG_OFS_BUS1_GATE;
   assign hit_bus1r = wb_req_i.adr == pcg_pkg::PCG_OFS_BUS1_RST;
   assign hit_bkp = wb_req_i.adr == pcg_pkg::PCG_OFS_BKP_CTRL;
   assign mapped = hit_fast | hit_bus2 | hit_bus1g | hit_bus1r | hit_bkp;

   always_comb begin
      ack_next = 1'b0;
      if (req) begin
         if (hit_bus1g) begin
            ack_next = ~busy_sync_reg; // [RQ8]
         end else if (hit_bkp) begin
            ack_next = wait_reg == pcg_pkg::PCG_BKP_WAIT_IDLE; // [RQ17]
         end else begin
            ack_next = 1'b1; // [RQ9]
         end
      end
   end

   // Back-to-back backup accesses pay the full wait; a lone one pays none
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_reg <= pcg_pkg::PCG_BKP_WAIT_IDLE;
      end else if (ack_reg) begin
         // Address still held in the ack cycle tells which register was served
         if (hit_bkp) begin
            wait_reg <= pcg_pkg::PCG_BKP_WAIT_B2B; // [RQ17]
         end else begin
            wait_reg <= pcg_pkg::PCG_BKP_WAIT_IDLE;
         end
      end else if (req && hit_bkp && wait_reg != pcg_pkg::PCG_BKP_WAIT_IDLE) begin
         wait_reg <= wait_reg - 2'h1; // [RQ17]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= ack_next;
      end
   end

   logic wr;
   assign wr = ack_next & wb_req_i.we;

   // ****************************************
   // Gate and reset registers
   // ****************************************
   logic [31:0] fast_reg;
   logic [31:0] bus2_reg;
   logic [31:0] bus1g_reg;
   logic [31:0] bus1r_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fast_reg <= pcg_pkg::PCG_RST_FAST_GATE; // [RQ4]
         bus2_reg <= pcg_pkg::PCG_RST_BUS2_GATE;
         bus1g_reg <= pcg_pkg::PCG_RST_BUS1_GATE;
         bus1r_reg <= pcg_pkg::PCG_RST_BUS1_RST;
      end else if (wr) begin
         if (hit_fast) begin
            fast_reg <= byte_merge(fast_reg, wb_req_i.dat, wb_req_i.sel,
                                   pcg_pkg::PCG_MSK_FAST_GATE); // [RQ2] [RQ3] [RQ22]
         end
         if (hit_bus2) begin
            bus2_reg <= byte_merge(bus2_reg, wb_req_i.dat, wb_req_i.sel,
                                   pcg_pkg::PCG_MSK_BUS2_GATE); // [RQ5] [RQ22]
         end
         if (hit_bus1g) begin
            bus1g_reg <= byte_merge(bus1g_reg, wb_req_i.dat, wb_req_i.sel,
                                    pcg_pkg::PCG_MSK_BUS1_GATE); // [RQ6] [RQ22]
         end
         if (hit_bus1r) begin
            bus1r_reg <= byte_merge(bus1r_reg, wb_req_i.dat, wb_req_i.sel,
                                    pcg_pkg::PCG_MSK_BUS1_RST); // [RQ7] [RQ22]
         end
      end
   end

   assign fast_gate_o = fast_reg;
   assign bus2_gate_o = bus2_reg;
   assign bus1_gate_o = bus1g_reg;
   assign bus1_rst_o = bus1r_reg; // [RQ21]

   // ****************************************
   // Backup-domain control
   // ****************************************
   // Only the backup-domain power-on or its own soft reset clears this; system
   // reset leaves it alone so the RTC keeps running across a chip reset.
   pcg_pkg::pcg_bkp_t bkp_reg;
   logic bkp_wr;
   logic [31:0] bkp_wdat;
   logic bkp_clear;

   pcg_pkg::pcg_bkp_t bkp_dflt;

   assign bkp_dflt = bkp_unpack(pcg_pkg::PCG_RST_BKP_CTRL);
   assign bkp_wr = wr & hit_bkp;
   assign bkp_wdat = byte_merge(bkp_pack(bkp_reg, 1'b0), wb_req_i.dat, wb_req_i.sel,
                                32'hFFFF_FFFF);
   assign bkp_clear = bpor_sync_reg | bkp_reg.bkp_rst;

   always_ff @(posedge clk_i) begin
      if (bpor_sync_reg) begin
         bkp_reg <= bkp_dflt; // [RQ16]
      end else if (bkp_wr) begin
         bkp_reg.bkp_rst <= bkp_wdat[pcg_pkg::PCG_BIT_BKP_RST]; // [RQ20]
         if (bkp_reg.bkp_rst) begin
            bkp_reg.xtal_en <= bkp_dflt.xtal_en;
            bkp_reg.xtal_byp <= bkp_dflt.xtal_byp;
            bkp_reg.xtal_drv <= bkp_dflt.xtal_drv; // [RQ13]
            bkp_reg.rtc_src <= bkp_dflt.rtc_src;
            bkp_reg.rtc_en <= bkp_dflt.rtc_en;
         end else begin
            bkp_reg.xtal_drv <= bkp_wdat[pcg_pkg::PCG_BIT_DRV_HI:pcg_pkg::PCG_BIT_DRV_LO];
            if (backup_write_unlock_i) begin
               bkp_reg.xtal_en <= bkp_wdat[pcg_pkg::PCG_BIT_XTAL_EN]; // [RQ10] [RQ18]
               bkp_reg.xtal_byp <= bkp_wdat[pcg_pkg::PCG_BIT_XTAL_BYP]; // [RQ12]
               bkp_reg.rtc_en <= bkp_wdat[pcg_pkg::PCG_BIT_RTC_EN]; // [RQ19]
               if (bkp_reg.rtc_src == pcg_pkg::PCG_SRC_NONE) begin
                  bkp_reg.rtc_src <= pcg_pkg::pcg_src_t'(
                     bkp_wdat[pcg_pkg::PCG_BIT_SRC_HI:pcg_pkg::PCG_BIT_SRC_LO]); // [RQ14] [RQ15]
               end
            end
         end
      end else if (bkp_clear) begin
         bkp_reg.xtal_en <= bkp_dflt.xtal_en;
         bkp_reg.xtal_byp <= bkp_dflt.xtal_byp;
         bkp_reg.xtal_drv <= bkp_dflt.xtal_drv;
         bkp_reg.rtc_src <= bkp_dflt.rtc_src; // [RQ20]
         bkp_reg.rtc_en <= bkp_dflt.rtc_en;
      end
   end

   assign bkp_ctrl_o = bkp_reg;
   assign bkp_domain_rst_o = bkp_clear; // [RQ20]

   // ****************************************
   // Read data
   // ****************************************
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_fast) rd_mux = fast_reg;
      if (hit_bus2) rd_mux = bus2_reg;
      if (hit_bus1g) rd_mux = bus1g_reg;
      if (hit_bus1r) rd_mux = bus1r_reg;
      if (hit_bkp) begin
         // Masked by enable so a stale pin level never reports a stopped crystal
         rd_mux = bkp_pack(bkp_reg, rdy_sync_reg & bkp_reg.xtal_en); // [RQ11] [RQ22]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_rsp_o <= '0;
      end else begin
         wb_rsp_o.ack <= ack_next & mapped;
         wb_rsp_o.err <= ack_next & ~mapped;
         wb_rsp_o.dat <= (ack_next & ~wb_req_i.we) ? rd_mux : 32'h0000_0000;
      end
   end

   // Peripheral reads are zero unless the mask bit is set in any of the three gate registers; mask input tells which gate bit serves it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_rdata_o <= 32'h0000_0000;
      end else if (periph_sel_i &&
                   |(periph_gate_mask_i & (fast_reg | bus2_reg | bus1g_reg))) begin
         periph_rdata_o <= periph_rdata_i;
      end else begin
         periph_rdata_o <= 32'h0000_0000; // [RQ1]
      end
   end

endmodule

// >>> dv/pcg_ctrl_assertions.sv
`timescale 1ns/1ps
module pcg_ctrl_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pcg_pkg::pcg_wb_req_t wb_req_i,
   input wire pcg_pkg::pcg_wb_rsp_t wb_rsp_o,
   input wire logic backup_write_unlock_i,
   input wire logic periph_sel_i,
   input wire logic [31:0] periph_gate_mask_i,
   input wire logic [31:0] periph_rdata_o,
   input wire logic [31:0] fast_gate_o,
   input wire logic [31:0] bus2_gate_o,
   input wire logic [31:0] bus1_gate_o,
   input wire logic [31:0] bus1_rst_o,
   input wire pcg_pkg::pcg_bkp_t bkp_ctrl_o,
   input wire logic bkp_domain_rst_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req_on;
   logic gated;
   logic bkp_wr;
   assign req_on = wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && !wb_rsp_o.err;
   assign gated = (periph_gate_mask_i & (fast_gate_o | bus2_gate_o | bus1_gate_o)) == 32'h0;
   assign bkp_wr = req_on && wb_req_i.we && wb_req_i.adr == 8'h20;
   a_ack_pulse: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack held longer than one cycle");
   a_gate_no_wait: assert property (req_on && wb_req_i.adr inside {8'h10, 8'h14, 8'h18}
      |=> wb_rsp_o.ack) else $error("gate register access waited");
   a_gated_zero: assert property (periph_sel_i && gated |=> periph_rdata_o == 32'h0)
      else $error("gated peripheral read not zero");
   a_reserved_zero: assert property (((fast_gate_o & ~pcg_pkg::PCG_MSK_FAST_GATE)
      | (bus2_gate_o & ~pcg_pkg::PCG_MSK_BUS2_GATE) | (bus1_gate_o & ~pcg_pkg::PCG_MSK_BUS1_GATE)
      | (bus1_rst_o & ~pcg_pkg::PCG_MSK_BUS1_RST)) == 32'h0) else $error("reserved bit set");
   a_rst_bit_held: assert property (!(req_on && wb_req_i.we && wb_req_i.adr == 8'h10)
      |=> $stable(bus1_rst_o)) else $error("reset bits changed without write");
   a_src_locked: assert property (bkp_ctrl_o.rtc_src != 2'h0 && !bkp_domain_rst_o
      |=> bkp_domain_rst_o || $stable(bkp_ctrl_o.rtc_src)) else $error("source changed");
   a_unlock_needed: assert property (bkp_wr && !backup_write_unlock_i && !bkp_domain_rst_o
      |=> bkp_domain_rst_o || $stable({bkp_ctrl_o.xtal_en, bkp_ctrl_o.xtal_byp,
      bkp_ctrl_o.rtc_src, bkp_ctrl_o.rtc_en})) else $error("locked field written");
   a_dom_rst_clears: assert property (bkp_domain_rst_o |=> bkp_ctrl_o.xtal_drv == 2'h3
      && bkp_ctrl_o.rtc_src == 2'h0 && !bkp_ctrl_o.xtal_en) else $error("domain reset ignored");
   c_err: cover property (wb_rsp_o.err);
   c_dom_rst: cover property (bkp_domain_rst_o ##1 !bkp_domain_rst_o);
   c_slow_bkp: cover property (req_on && wb_req_i.adr == 8'h20 ##4 wb_rsp_o.ack);
endmodule
bind pcg_ctrl pcg_ctrl_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
   .wb_rsp_o(wb_rsp_o), .backup_write_unlock_i(backup_write_unlock_i),
   .periph_sel_i(periph_sel_i), .periph_gate_mask_i(periph_gate_mask_i),
   .periph_rdata_o(periph_rdata_o), .fast_gate_o(fast_gate_o), .bus2_gate_o(bus2_gate_o),
   .bus1_gate_o(bus1_gate_o), .bus1_rst_o(bus1_rst_o), .bkp_ctrl_o(bkp_ctrl_o),
   .bkp_domain_rst_o(bkp_domain_rst_o));

// >>> dv/pcg_ctrl_tb.sv
`timescale 1ns/1ps
module pcg_ctrl_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic por = 1'b1;
   logic unl = 1'b0;
   logic stab = 1'b0;
   logic busy = 1'b0;
   logic psel = 1'b0;
   logic le;
   logic drst;
   logic [31:0] pmask = 32'h0;
   logic [31:0] pdin = 32'h0;
   logic [31:0] pdout, fast, bus2, bus1, prst, q;
   pcg_pkg::pcg_wb_req_t req = '0;
   pcg_pkg::pcg_wb_rsp_t rsp;
   pcg_pkg::pcg_bkp_t bkp;
   int err_total = 0;
   int checks = 0;
   int cyc_cnt = 0;
   int n1, n2;
   always #2 clk_i = ~clk_i;
   pcg_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .bkp_por_i(por), .wb_req_i(req),
      .wb_rsp_o(rsp), .backup_write_unlock_i(unl), .slow_crystal_stable_i(stab),
      .bus1_periph_busy_i(busy), .periph_sel_i(psel), .periph_gate_mask_i(pmask),
      .periph_rdata_i(pdin), .periph_rdata_o(pdout), .fast_gate_o(fast), .bus2_gate_o(bus2),
      .bus1_gate_o(bus1), .bus1_rst_o(prst), .bkp_ctrl_o(bkp), .bkp_domain_rst_o(drst));
   // ****************************************
   // Bus and compare helpers
   // ****************************************
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // No fixed latency assumed; only the timeout ends a hung wait
   task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
                     input logic [31:0] d, output int n);
      req <= '{1'b1, 1'b1, w, a, s, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && rsp.err !== 1'b1);
      q = rsp.dat;
      le = rsp.err;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(a, 1'b1, 4'hF, d, n1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      wb(a, 1'b0, 4'hF, 32'h0, n1);
      chk(nm, e, q);
   endtask
   task automatic pr(input logic [31:0] mk, input logic [31:0] e);
      psel <= 1'b1;
      pmask <= mk;
      pdin <= 32'hA5C3_3C5A;
      @(posedge clk_i);
      psel <= 1'b0;
      @(posedge clk_i);
      chk("periph_rd", e, pdout);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rd(8'h14, 32'h0000_0014, "fast_rst");
      rd(8'h18, 32'h0, "bus2_rst");
      rd(8'h1C, 32'h0, "bus1_rst");
      rd(8'h10, 32'h0, "prst_rst");
      rd(8'h20, 32'h0000_0018, "bkp_rst");
      $display("t_reset done");
   endtask
   task automatic t_regs();
      logic [7:0] a [4] = '{8'h10, 8'h14, 8'h18, 8'h1C};
      logic [31:0] m [4] = '{32'h1222_0900, 32'h014E_0055, 32'h0041_5A01, 32'h1222_0913};
      for (int i = 0; i < 4; i++) begin
         wr(a[i], 32'hFFFF_FFFF);
         rd(a[i], m[i], "reg_ones");
      end
      chk("fast_o", m[1], fast);
      chk("bus2_o", m[2], bus2);
      repeat (5) @(posedge clk_i);
      chk("prst_hold", m[0], prst);
      wr(8'h10, 32'h0);
      chk("prst_free", 32'h0, prst);
      wb(8'h14, 1'b1, 4'h1, 32'h0, n1);
      chk("fast_byte", 32'h014E_0000, fast);
      chk("fast_lat", 32'h2, n1);
      wb(8'h14, 1'b1, 4'hC, 32'h0, n1);
      chk("fast_half", 32'h0, fast);
      $display("t_regs done");
   endtask
   task automatic t_gate();
      pr(32'h0000_0040, 32'h0);
      pr(32'h0000_0200, 32'hA5C3_3C5A);
      wr(8'h18, 32'h0);
      pr(32'h0000_0200, 32'h0);
      $display("t_gate done");
   endtask
   task automatic t_stall();
      busy <= 1'b1;
      repeat (3) @(posedge clk_i);
      fork
         begin
            repeat (8) @(posedge clk_i);
            busy <= 1'b0;
         end
      join_none
      wb(8'h1C, 1'b1, 4'hF, 32'h1, n1);
      chk("stall", 32'h1, {31'h0, n1 > 8});
      chk("bus1_o", 32'h1, bus1);
      $display("t_stall done");
   endtask
   task automatic t_bkp();
      wr(8'h20, 32'h0000_8105);
      rd(8'h20, 32'h0, "bkp_locked");
      unl <= 1'b1;
      wr(8'h20, 32'h0000_811D);
      rd(8'h20, 32'h0000_811D, "bkp_open");
      chk("bkp_o", 32'h0000_00F6, {24'h0, bkp});
      stab <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(8'h20, 32'h0000_811F, "ready_set");
      stab <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(8'h20, 32'h0000_811D, "ready_clr");
      wr(8'h20, 32'h0000_821D);
      rd(8'h20, 32'h0000_811D, "src_locked");
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(8'h20, 32'h0000_811D, "sysrst_keep");
      rd(8'h14, 32'h0000_0014, "fast_sysrst");
      for (int s = 0; s < 4; s++) begin
         wr(8'h20, 32'h0001_0000);
         chk("dom_rst", 32'h1, {31'h0, drst});
         wr(8'h20, 32'h0);
         rd(8'h20, 32'h0000_0018, "dom_rst_val");
         wr(8'h20, {22'h0, 2'(s), 8'h18});
         chk("src_o", 32'(s), {30'h0, bkp.rtc_src});
      end
      $display("t_bkp done");
   endtask
   task automatic t_lat();
      wb(8'h14, 1'b0, 4'hF, 32'h0, n1);
      wb(8'h20, 1'b0, 4'hF, 32'h0, n1);
      wb(8'h20, 1'b0, 4'hF, 32'h0, n2);
      chk("b2b_wait", 32'h1, {31'h0, n2 > n1});
      chk("wait_max", 32'h1, {31'h0, n2 <= 5});
      wb(8'h04, 1'b0, 4'hF, 32'h0, n1);
      chk("unmapped", 32'h1, {31'h0, le});
      $display("t_lat done");
   endtask
   // Ceiling well above the few hundred cycles the scenarios need
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      por <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_reset();
      t_regs();
      t_gate();
      t_stall();
      t_bkp();
      t_lat();
      final_report();
   end
endmodule
